// [rtl/bdm_cfg.svh]
// Timing, field and reset constants of the backlight dimming control.
// Assumes a 100 MHz core clock; included by the device end and the host end.
`ifndef BDM_CFG_SVH
`define BDM_CFG_SVH
`define BDM_CLK_MHZ 100
// Mode detection, shutdown and duty-mode timing, in microseconds except the dimming shutdown in milliseconds
`define BDM_T_DELAY_US 300
`define BDM_T_DET_US 400
`define BDM_T_WIN_US 1230
`define BDM_T_EN_SD_US 2500
`define BDM_T_PWM_SD_MS 20
`define BDM_T_PWM_STEP_US 64
`define BDM_T_PWM_FULL_US 100
// Coded stream framing, in microseconds
`define BDM_T_START_US 3
`define BDM_T_EOS_US 3
`define BDM_T_BIT_MAX_US 360
// Ramp step times selected by the 3-bit ramp fields
`define BDM_RAMP0_US 4
`define BDM_RAMP1_US 8
`define BDM_RAMP2_US 16
`define BDM_RAMP3_US 64
`define BDM_RAMP4_US 256
`define BDM_RAMP5_US 1024
`define BDM_RAMP6_US 2048
`define BDM_RAMP7_US 4096
// Frame layout, LSB first: code, then ramp down, then ramp up
`define BDM_FRAME_BITS 16
`define BDM_CODE_W 10
`define BDM_RDN_LSB 10
`define BDM_RUP_LSB 13
`define BDM_RAMP_W 3
`define BDM_CODE_RST 10'h000
`define BDM_RAMP_RST 3'h1
`define BDM_FULL_SCALE 11'h400
// Host side timing with margin over the device minimums
`define BDM_H_DELAY_US 350
`define BDM_H_DET_US 500
`define BDM_H_SD_US 3000
`define BDM_H_SHORT_US 3
`define BDM_H_LONG_US 7
`define BDM_H_START_US 5
`define BDM_H_EOS_US 5
`endif

// [rtl/bdm_pkg.sv]
// Types shared by the device end and the host end.
// Assumes nothing beyond a SystemVerilog compiler.
package bdm_pkg;
  // Device operating states
  typedef enum logic [4:0] {
    DEV_OFF    = 5'h01,
    DEV_DETECT = 5'h02,
    DEV_WIRE   = 5'h04,
    DEV_PWM    = 5'h08,
    DEV_LATCH  = 5'h10
  } bdm_dev_state_e;
  // Host sequencing states
  typedef enum logic [9:0] {
    HST_OFF    = 10'h001,
    HST_DELAY  = 10'h002,
    HST_DETLOW = 10'h004,
    HST_IDLE   = 10'h008,
    HST_START  = 10'h010,
    HST_BITLO  = 10'h020,
    HST_BITHI  = 10'h040,
    HST_EOS    = 10'h080,
    HST_PWM    = 10'h100,
    HST_SHUT   = 10'h200
  } bdm_host_state_e;
endpackage

// [rtl/bdm_link_if.sv]
// Enable and dimming pins between host controller and driver.
// Both pins are driven only by the host; the device only samples them.
`timescale 1ns/100ps
interface bdm_link_if;
  logic en;  // Enable and coded dimming pin
  logic pwm; // Duty-cycle dimming pin
  modport host (output en, output pwm);
  modport dev (input en, input pwm);
endinterface

// [rtl/bdm_low_timer.sv]
// Counts how long a level has stayed low while armed.
// Assumes the level is already synchronised to i_mclk.
`timescale 1ns/100ps
module bdm_low_timer #(
  parameter int W = 22,
  parameter int LIMIT = 1000
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_arm,
  input wire logic i_level,
  output logic o_expired
);
  logic [W-1:0] cnt_ff; // Low time so far, saturating

  // Restart on any high level or while disarmed
  always_ff @(posedge i_mclk) begin
    if (i_reset || !i_arm || i_level) begin
      cnt_ff <= '0;
    end else if (cnt_ff != {W{1'b1}}) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // Registered flag; one cycle late, well inside the margin
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_expired <= 1'b0;
    end else begin
      o_expired <= i_arm && !i_level && (cnt_ff >= W'(LIMIT));
    end
  end
endmodule

// [rtl/bdm_device.sv]
// Driver-side control: mode detection, coded and duty-cycle dimming,
// current ramping and protection shutdowns.
// Assumes the pins come from another domain and fault inputs are
// already registered on i_mclk by the analogue wrapper.
`timescale 1ns/100ps
`include "bdm_cfg.svh"
module bdm_device import bdm_pkg::*; #(
  parameter int P_DELAY_CYC = `BDM_T_DELAY_US * `BDM_CLK_MHZ,
  parameter int P_DET_CYC = `BDM_T_DET_US * `BDM_CLK_MHZ,
  parameter int P_WIN_CYC = `BDM_T_WIN_US * `BDM_CLK_MHZ,
  parameter int P_EN_SD_CYC = `BDM_T_EN_SD_US * `BDM_CLK_MHZ,
  parameter int P_PWM_SD_CYC = `BDM_T_PWM_SD_MS * 1000 * `BDM_CLK_MHZ,
  parameter int P_PWM_STEP_CYC = `BDM_T_PWM_STEP_US * `BDM_CLK_MHZ,
  parameter int P_PWM_FULL_CYC = `BDM_T_PWM_FULL_US * `BDM_CLK_MHZ,
  parameter int P_BIT_MAX_CYC = `BDM_T_BIT_MAX_US * `BDM_CLK_MHZ
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  bdm_link_if.dev link,
  input wire logic i_ocp,
  input wire logic i_cycle_start,
  input wire logic i_temp_high,
  input wire logic i_temp_low,
  input wire logic i_ovp,
  output logic o_switch_en,
  output logic o_boost_en,
  output logic o_sink_en,
  output logic [10:0] o_led_current_code,
  output logic [2:0] o_ramp_up,
  output logic [2:0] o_ramp_down,
  output logic o_wire_mode,
  output logic o_pwm_mode
);
  localparam int START_CYC = `BDM_T_START_US * `BDM_CLK_MHZ;
  localparam int EOS_CYC = `BDM_T_EOS_US * `BDM_CLK_MHZ;

  bdm_dev_state_e st_ff, nxt_st;
  logic en_s1_ff, en_s2_ff, en_d_ff; // Enable pin synchroniser
  logic pw_s1_ff, pw_s2_ff, pw_d_ff; // Dimming pin synchroniser
  logic en_rise, en_fall, pw_rise, pw_fall;
  logic en_sd, pwm_sd; // Low-time shutdown requests
  logic [16:0] ph_cnt_ff; // Length of current enable phase
  logic [16:0] win_cnt_ff; // Time since detection opened
  logic [16:0] lo_len_ff; // Last low phase length
  logic det_ok_ff; // Long first high seen in window
  logic fell_ff; // First fall in window already judged
  logic in_frame_ff; // Coded frame in progress
  logic [4:0] bit_cnt_ff; // Bits received in this frame
  logic [15:0] shreg_ff; // Incoming frame, LSB first
  logic [9:0] code_ff; // Stored brightness_code
  logic [2:0] rup_ff, rdn_ff; // Stored ramp step selections
  logic [15:0] pw_cnt_ff; // Cycles since last dimming rise
  logic [15:0] hi_len_ff; // High cycles of last dimming period
  logic [10:0] duty_ff; // Measured duty, full scale 1024
  logic [25:0] quot; // Duty division result
  logic [10:0] cur_ff, tgt; // Present and target current code
  logic [18:0] step_ff, step_len; // Ramp step timing
  logic otp_ff, ocp_ff; // Protection flags

  // Two flops on each pin before any logic looks at it
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      {en_s1_ff, en_s2_ff, en_d_ff} <= 3'h0;
      {pw_s1_ff, pw_s2_ff, pw_d_ff} <= 3'h0;
    end else begin
      {en_s1_ff, en_s2_ff, en_d_ff} <= {link.en, en_s1_ff, en_s2_ff};
      {pw_s1_ff, pw_s2_ff, pw_d_ff} <= {link.pwm, pw_s1_ff, pw_s2_ff};
    end
  end
  assign en_rise = en_s2_ff & ~en_d_ff;
  assign en_fall = ~en_s2_ff & en_d_ff;
  assign pw_rise = pw_s2_ff & ~pw_d_ff;
  assign pw_fall = ~pw_s2_ff & pw_d_ff;

  // Enable held low ends coded and duty-cycle modes
  bdm_low_timer #(.W(19), .LIMIT(P_EN_SD_CYC)) u_en_sd (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_arm(st_ff != DEV_OFF),
    .i_level(en_s2_ff),
    .o_expired(en_sd)
  );
  // Dimming held low ends duty-cycle mode
  bdm_low_timer #(.W(22), .LIMIT(P_PWM_SD_CYC)) u_pwm_sd (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_arm(st_ff == DEV_PWM),
    .i_level(pw_s2_ff),
    .o_expired(pwm_sd)
  );

  // Mode selection; once in a mode only shutdown leaves it
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      DEV_OFF: begin
        if (en_rise) nxt_st = DEV_DETECT;
      end
      DEV_DETECT: begin
        if (i_ovp) nxt_st = DEV_LATCH;
        else if (en_rise && det_ok_ff && ph_cnt_ff > 17'(P_DET_CYC) &&
                 win_cnt_ff < 17'(P_WIN_CYC)) nxt_st = DEV_WIRE;
        else if (win_cnt_ff >= 17'(P_WIN_CYC)) nxt_st = DEV_PWM;
      end
      DEV_WIRE: begin
        if (i_ovp) nxt_st = DEV_LATCH;
        else if (en_sd) nxt_st = DEV_OFF;
      end
      DEV_PWM: begin
        if (i_ovp) nxt_st = DEV_LATCH;
        else if (en_sd || pwm_sd) nxt_st = DEV_OFF;
      end
      DEV_LATCH: begin
        // Only a toggle of enable rearms the part
        if (!en_s2_ff) nxt_st = DEV_OFF;
      end
      default: nxt_st = DEV_OFF;
    endcase
  end

  // State register
  always_ff @(posedge i_mclk) begin
    if (i_reset) st_ff <= DEV_OFF;
    else st_ff <= nxt_st;
  end

  // Phase length restarts on each enable edge, saturating
  always_ff @(posedge i_mclk) begin
    if (i_reset || en_rise || en_fall) ph_cnt_ff <= 17'h00001;
    else if (ph_cnt_ff != 17'h1FFFF) ph_cnt_ff <= ph_cnt_ff + 17'h00001;
  end

  // Detection window timer and first-high check
  always_ff @(posedge i_mclk) begin
    if (i_reset || st_ff != DEV_DETECT) begin
      win_cnt_ff <= 17'h00000;
      det_ok_ff <= 1'b0;
      fell_ff <= 1'b0;
    end else begin
      if (win_cnt_ff != 17'h1FFFF) win_cnt_ff <= win_cnt_ff + 17'h00001;
      if (en_fall && !fell_ff) begin
        det_ok_ff <= (ph_cnt_ff > 17'(P_DELAY_CYC));
        fell_ff <= 1'b1;
      end else if (en_rise) begin
        det_ok_ff <= 1'b0; // A failed pattern is not retried
      end
    end
  end

  // Coded frame receiver; runs as soon as the mode is entered
  always_ff @(posedge i_mclk) begin
    if (i_reset || st_ff != DEV_WIRE) begin
      in_frame_ff <= 1'b0;
      bit_cnt_ff <= 5'h00;
      shreg_ff <= 16'h0000;
      lo_len_ff <= 17'h00000;
    end else if (en_fall) begin
      if (!in_frame_ff) begin
        // Idle high long enough opens a frame
        in_frame_ff <= (ph_cnt_ff >= 17'(START_CYC));
        bit_cnt_ff <= 5'h00;
      end else if (bit_cnt_ff < 5'(`BDM_FRAME_BITS)) begin
        // Longer high than low is a one
        shreg_ff <= {ph_cnt_ff > lo_len_ff, shreg_ff[15:1]};
        bit_cnt_ff <= bit_cnt_ff + 5'h01;
      end
    end else if (en_rise) begin
      lo_len_ff <= ph_cnt_ff;
      if (bit_cnt_ff == 5'(`BDM_FRAME_BITS)) begin
        in_frame_ff <= 1'b0; // Frame done either way
        bit_cnt_ff <= 5'h00;
      end
    end else if (in_frame_ff && ph_cnt_ff >= 17'(P_BIT_MAX_CYC) &&
                 (en_s2_ff || bit_cnt_ff != 5'(`BDM_FRAME_BITS))) begin
      in_frame_ff <= 1'b0; // Stalled phase drops the frame
      bit_cnt_ff <= 5'h00;
    end
  end

  // Stored code and ramp fields; taken only after a clean end
  always_ff @(posedge i_mclk) begin
    if (i_reset || st_ff == DEV_OFF || st_ff == DEV_LATCH) begin
      code_ff <= `BDM_CODE_RST;
      rup_ff <= `BDM_RAMP_RST;
      rdn_ff <= `BDM_RAMP_RST;
    end else if (st_ff == DEV_WIRE && en_rise && in_frame_ff &&
                 bit_cnt_ff == 5'(`BDM_FRAME_BITS) &&
                 ph_cnt_ff >= 17'(EOS_CYC)) begin
      code_ff <= shreg_ff[`BDM_CODE_W-1:0];
      rdn_ff <= shreg_ff[`BDM_RDN_LSB +: `BDM_RAMP_W];
      rup_ff <= shreg_ff[`BDM_RUP_LSB +: `BDM_RAMP_W];
    end
  end

  // Duty measurement: period rise to rise, high rise to fall
  assign quot = {hi_len_ff, 10'h000} / {10'h000, pw_cnt_ff};
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      pw_cnt_ff <= 16'h0000;
      hi_len_ff <= 16'h0000;
      duty_ff <= 11'h000;
    end else begin
      if (pw_rise) pw_cnt_ff <= 16'h0001;
      else if (pw_cnt_ff != 16'hFFFF) pw_cnt_ff <= pw_cnt_ff + 16'h0001;
      if (pw_fall) hi_len_ff <= pw_cnt_ff;
      if (pw_rise && pw_cnt_ff != 16'h0000) begin
        duty_ff <= (quot > 26'(`BDM_FULL_SCALE)) ? `BDM_FULL_SCALE
                                                 : quot[10:0];
      end else if (pw_cnt_ff >= 16'(P_PWM_FULL_CYC)) begin
        // No edge for a long time: steady level
        duty_ff <= pw_s2_ff ? `BDM_FULL_SCALE : 11'h000;
      end
    end
  end

  // Ramp step time for the selected field
  function automatic logic [18:0] ramp_cyc(input logic [2:0] sel);
    case (sel)
      3'h0: ramp_cyc = 19'(`BDM_RAMP0_US * `BDM_CLK_MHZ);
      3'h1: ramp_cyc = 19'(`BDM_RAMP1_US * `BDM_CLK_MHZ);
      3'h2: ramp_cyc = 19'(`BDM_RAMP2_US * `BDM_CLK_MHZ);
      3'h3: ramp_cyc = 19'(`BDM_RAMP3_US * `BDM_CLK_MHZ);
      3'h4: ramp_cyc = 19'(`BDM_RAMP4_US * `BDM_CLK_MHZ);
      3'h5: ramp_cyc = 19'(`BDM_RAMP5_US * `BDM_CLK_MHZ);
      3'h6: ramp_cyc = 19'(`BDM_RAMP6_US * `BDM_CLK_MHZ);
      default: ramp_cyc = 19'(`BDM_RAMP7_US * `BDM_CLK_MHZ);
    endcase
  endfunction

  // Target and step length by mode
  always_comb begin
    tgt = 11'h000;
    if (st_ff == DEV_WIRE) tgt = {1'b0, code_ff};
    else if (st_ff == DEV_PWM) tgt = duty_ff;
    if (st_ff == DEV_PWM) step_len = 19'(P_PWM_STEP_CYC);
    else step_len = ramp_cyc((cur_ff < tgt) ? rup_ff : rdn_ff);
  end

  // Current walks one code per step; an over-temperature or over-voltage trip restarts from zero
  always_ff @(posedge i_mclk) begin
    if (i_reset || otp_ff || st_ff == DEV_OFF || st_ff == DEV_LATCH) begin
      cur_ff <= 11'h000;
      step_ff <= 19'h00000;
    end else if (cur_ff == tgt) begin
      step_ff <= 19'h00000;
    end else if (step_ff >= step_len - 19'h00001) begin
      step_ff <= 19'h00000;
      cur_ff <= (cur_ff < tgt) ? cur_ff + 11'h001 : cur_ff - 11'h001;
    end else begin
      step_ff <= step_ff + 19'h00001;
    end
  end

  // Protection flags; a new trip beats its own release
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      otp_ff <= 1'b0;
      ocp_ff <= 1'b0;
    end else begin
      if (i_temp_high) otp_ff <= 1'b1;
      else if (i_temp_low) otp_ff <= 1'b0;
      if (i_ocp) ocp_ff <= 1'b1;
      else if (i_cycle_start) ocp_ff <= 1'b0;
    end
  end

  // Registered outputs
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_switch_en <= 1'b0;
      o_boost_en <= 1'b0;
      o_sink_en <= 1'b0;
      o_wire_mode <= 1'b0;
      o_pwm_mode <= 1'b0;
    end else begin
      o_boost_en <= (nxt_st != DEV_OFF) && (nxt_st != DEV_LATCH) && !otp_ff;
      o_sink_en <= (nxt_st == DEV_WIRE || nxt_st == DEV_PWM) && !otp_ff;
      o_switch_en <= (nxt_st != DEV_OFF) && (nxt_st != DEV_LATCH) &&
                     !otp_ff && !i_ocp && !i_ovp &&
                     (!ocp_ff || i_cycle_start);
      o_wire_mode <= (nxt_st == DEV_WIRE);
      o_pwm_mode <= (nxt_st == DEV_PWM);
    end
  end
  assign o_led_current_code = cur_ff;
  assign o_ramp_up = rup_ff;
  assign o_ramp_down = rdn_ff;
endmodule

// [rtl/bdm_host.sv]
// Host controller end: power-up with or without the coded-mode
// pattern, 16-bit coded frames, duty-cycle generation, shutdown.
// Assumes user requests are one-cycle pulses on i_mclk.
`timescale 1ns/100ps
`include "bdm_cfg.svh"
module bdm_host import bdm_pkg::*; #(
  parameter int P_DELAY_CYC = `BDM_H_DELAY_US * `BDM_CLK_MHZ,
  parameter int P_DET_CYC = `BDM_H_DET_US * `BDM_CLK_MHZ,
  parameter int P_SD_CYC = `BDM_H_SD_US * `BDM_CLK_MHZ
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  bdm_link_if.host link,
  input wire logic i_power_wire,
  input wire logic i_power_pwm,
  input wire logic i_send,
  input wire logic [15:0] i_frame,
  input wire logic i_shutdown,
  input wire logic [15:0] i_pwm_high,
  input wire logic [15:0] i_pwm_period,
  output logic o_busy,
  output logic o_wire_ready,
  output logic o_pwm_run
);
  localparam int SHORT_CYC = `BDM_H_SHORT_US * `BDM_CLK_MHZ;
  localparam int LONG_CYC = `BDM_H_LONG_US * `BDM_CLK_MHZ;
  localparam int START_CYC = `BDM_H_START_US * `BDM_CLK_MHZ;
  localparam int EOS_CYC = `BDM_H_EOS_US * `BDM_CLK_MHZ;

  bdm_host_state_e st_ff, nxt_st;
  logic [18:0] cnt_ff; // Time in present state
  logic [15:0] frame_ff; // Frame being sent, shifted LSB first
  logic [3:0] idx_ff; // Bit being sent
  logic [15:0] pcnt_ff; // Dimming period position
  logic en_ff, pwm_ff; // Pin drivers
  logic [18:0] lo_t, hi_t; // Phase lengths for the current bit

  // Zero: long low, short high; one: the reverse
  assign lo_t = frame_ff[0] ? 19'(SHORT_CYC) : 19'(LONG_CYC);
  assign hi_t = frame_ff[0] ? 19'(LONG_CYC) : 19'(SHORT_CYC);

  // Sequencing of the enable pin
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      HST_OFF: begin
        if (i_power_wire) nxt_st = HST_DELAY;
        else if (i_power_pwm) nxt_st = HST_PWM;
      end
      HST_DELAY: begin
        if (cnt_ff >= 19'(P_DELAY_CYC)) nxt_st = HST_DETLOW;
      end
      HST_DETLOW: begin
        if (cnt_ff >= 19'(P_DET_CYC)) nxt_st = HST_IDLE;
      end
      HST_IDLE: begin
        if (i_shutdown) nxt_st = HST_SHUT;
        else if (i_send) nxt_st = HST_START;
      end
      HST_START: begin
        if (cnt_ff >= 19'(START_CYC)) nxt_st = HST_BITLO;
      end
      HST_BITLO: begin
        if (cnt_ff >= lo_t) nxt_st = HST_BITHI;
      end
      HST_BITHI: begin
        if (cnt_ff >= hi_t) begin
          nxt_st = (idx_ff == 4'hF) ? HST_EOS : HST_BITLO;
        end
      end
      HST_EOS: begin
        if (cnt_ff >= 19'(EOS_CYC)) nxt_st = HST_IDLE;
      end
      HST_PWM: begin
        if (i_shutdown) nxt_st = HST_SHUT;
      end
      HST_SHUT: begin
        if (cnt_ff >= 19'(P_SD_CYC)) nxt_st = HST_OFF;
      end
      default: nxt_st = HST_OFF;
    endcase
  end

  // State and its timer
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      st_ff <= HST_OFF;
      cnt_ff <= 19'h00000;
    end else begin
      st_ff <= nxt_st;
      if (nxt_st != st_ff) cnt_ff <= 19'h00001;
      else if (cnt_ff != 19'h7FFFF) cnt_ff <= cnt_ff + 19'h00001;
    end
  end

  // Frame shifter: latched at send, advanced after each high phase
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      frame_ff <= 16'h0000;
      idx_ff <= 4'h0;
    end else if (st_ff == HST_IDLE && nxt_st == HST_START) begin
      frame_ff <= i_frame;
      idx_ff <= 4'h0;
    end else if (st_ff == HST_BITHI && nxt_st != HST_BITHI) begin
      frame_ff <= {1'b0, frame_ff[15:1]};
      idx_ff <= idx_ff + 4'h1;
    end
  end

  // Dimming generator; user keeps the period in the 20-100 kHz band
  always_ff @(posedge i_mclk) begin
    if (i_reset || nxt_st != HST_PWM) begin
      pcnt_ff <= 16'h0000;
    end else if (pcnt_ff + 16'h0001 >= i_pwm_period) begin
      pcnt_ff <= 16'h0000;
    end else begin
      pcnt_ff <= pcnt_ff + 16'h0001;
    end
  end

  // Pins and status, all registered
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      en_ff <= 1'b0;
      pwm_ff <= 1'b0;
      o_busy <= 1'b0;
      o_wire_ready <= 1'b0;
      o_pwm_run <= 1'b0;
    end else begin
      en_ff <= (nxt_st == HST_DELAY) || (nxt_st == HST_IDLE) ||
               (nxt_st == HST_START) || (nxt_st == HST_BITHI) ||
               (nxt_st == HST_PWM);
      pwm_ff <= (nxt_st == HST_PWM) && (pcnt_ff < i_pwm_high);
      o_busy <= (nxt_st != HST_OFF) && (nxt_st != HST_IDLE) &&
                (nxt_st != HST_PWM);
      o_wire_ready <= (nxt_st == HST_IDLE);
      o_pwm_run <= (nxt_st == HST_PWM);
    end
  end
  assign link.en = en_ff;
  assign link.pwm = pwm_ff;
endmodule

// [verification/bdm_link_props.sv]
// Concurrent checks on the link pins and the device end's outputs.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
module bdm_link_props #(
  parameter int P_EN_SD_CYC = 2500,
  parameter int P_PWM_SD_CYC = 20000,
  parameter int P_PWM_STEP_CYC = 64
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic en,
  input wire logic pwm,
  input wire logic i_ocp,
  input wire logic i_temp_high,
  input wire logic i_ovp,
  input wire logic o_switch_en,
  input wire logic o_boost_en,
  input wire logic o_sink_en,
  input wire logic [10:0] o_led_current_code,
  input wire logic o_wire_mode,
  input wire logic o_pwm_mode
);
  logic [23:0] en_low_ff; // Cycles with enable low
  logic [23:0] pwm_low_ff; // Low dimming cycles while in duty mode
  logic [10:0] cur_prev_ff; // Current code one sample earlier
  logic [15:0] run_ff; // Samples the current code has stayed put
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // Enable low time, saturating so it never wraps back to the limit
  always_ff @(posedge i_mclk) begin
    if (i_reset || en) begin
      en_low_ff <= 24'h000000;
    end else if (en_low_ff != 24'hFFFFFF) begin
      en_low_ff <= en_low_ff + 24'h000001;
    end
  end
  // Dimming low time, counted only while duty mode is active
  always_ff @(posedge i_mclk) begin
    if (i_reset || pwm || !o_pwm_mode) begin
      pwm_low_ff <= 24'h000000;
    end else if (pwm_low_ff != 24'hFFFFFF) begin
      pwm_low_ff <= pwm_low_ff + 24'h000001;
    end
  end
  // Run length of an unchanged current code; a shutdown reset to zero
  // happens after the mode flag drops, so it never looks like a step
  always_ff @(posedge i_mclk) begin
    cur_prev_ff <= o_led_current_code;
    if (i_reset || o_led_current_code != cur_prev_ff) begin
      run_ff <= 16'h0000;
    end else if (run_ff != 16'hFFFF) begin
      run_ff <= run_ff + 16'h0001;
    end
  end
  sequence s_switch_cut;
    ##[1:2] !o_switch_en;
  endsequence
  sequence s_sinks_off;
    ##[1:3] (!o_sink_en && !o_boost_en);
  endsequence
  sequence s_all_off;
    ##[1:3] (!o_boost_en && !o_wire_mode && !o_pwm_mode);
  endsequence
  a_ocp_cuts_switch: assert property (i_ocp |-> s_switch_cut)
    else $error("switch stayed on after over-current");
  a_otp_stops_sinks: assert property (i_temp_high |-> s_sinks_off)
    else $error("sinks or boost on while too hot");
  a_ovp_shuts_down: assert property (i_ovp |-> s_all_off)
    else $error("device still on after over-voltage");
  a_en_low_off: assert property ((en_low_ff == P_EN_SD_CYC + 8) |->
    (!o_wire_mode && !o_pwm_mode))
    else $error("device on after long enable low");
  a_pwm_low_off: assert property ((pwm_low_ff == P_PWM_SD_CYC + 8) |->
    !o_pwm_mode)
    else $error("duty mode on after long dimming low");
  a_mode_single: assert property (!(o_wire_mode && o_pwm_mode))
    else $error("both dimming modes active");
  a_no_mode_swap: assert property ($rose(o_pwm_mode) |->
    !$past(o_wire_mode))
    else $error("mode changed without shutdown");
  a_code_in_range: assert property (o_led_current_code <= 11'h400)
    else $error("current code above full scale");
  a_pwm_step_hold: assert property ((o_pwm_mode && $past(o_pwm_mode) &&
    (o_led_current_code != cur_prev_ff)) |->
    (run_ff >= 16'(P_PWM_STEP_CYC - 1)))
    else $error("duty ramp stepped too fast");
  a_wire_needs_en: assert property ($rose(o_wire_mode) |-> en)
    else $error("coded mode entered with enable low");
endmodule

// [verification/bdm_test.sv]
// Bench joining host end and device end; drives user and fault inputs.
// Assumes shortened detect and shutdown times; counts are 10 ns cycles.
`timescale 1ns/100ps
module bdm_test import bdm_pkg::*;;
  localparam int EN_SD = 2500; // Enable low cycles to shutdown
  localparam int PWM_SD = 20000; // Dimming low cycles to shutdown
  localparam int DLY = 300; // First high time before the detect low
  localparam int DET = 400; // Detect low time
  localparam int WIN = 1230; // Detection window
  localparam int STEP = 64; // Duty-mode ramp step
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic power_wire = 1'b0, power_pwm = 1'b0, send = 1'b0, shut = 1'b0;
  logic ocp = 1'b0, cyc = 1'b0, t_hi = 1'b0, t_lo = 1'b1, ovp = 1'b0;
  logic [15:0] frame = 16'h0000, pwm_high = 16'h00FA;
  logic [15:0] pwm_period = 16'h03E8; // 100 kHz at the core clock
  logic busy, wire_ready, pwm_run, sw_en, boost_en, sink_en;
  logic wire_m, pwm_m;
  logic [10:0] cur;
  logic [2:0] rup, rdn;
  int miscompares = 0;
  int n_compared = 0;
  bdm_link_if bdm_link_if_i();
  // Free-running core clock
  always #5 i_mclk = ~i_mclk;
  // Host keeps a margin over each device minimum
  bdm_host #(.P_DELAY_CYC(DLY + 50), .P_DET_CYC(DET + 100),
    .P_SD_CYC(EN_SD + 500)) bdm_host_i (
    .i_mclk(i_mclk), .i_reset(i_reset), .link(bdm_link_if_i),
    .i_power_wire(power_wire), .i_power_pwm(power_pwm), .i_send(send),
    .i_frame(frame), .i_shutdown(shut), .i_pwm_high(pwm_high),
    .i_pwm_period(pwm_period), .o_busy(busy), .o_wire_ready(wire_ready),
    .o_pwm_run(pwm_run));
  // Full-duty timeout and bit limit keep their real lengths: both
  // must exceed the dimming period and the host bit phases
  bdm_device #(.P_DELAY_CYC(DLY), .P_DET_CYC(DET), .P_WIN_CYC(WIN),
    .P_EN_SD_CYC(EN_SD), .P_PWM_SD_CYC(PWM_SD),
    .P_PWM_STEP_CYC(STEP)) bdm_device_i (
    .i_mclk(i_mclk), .i_reset(i_reset), .link(bdm_link_if_i), .i_ocp(ocp),
    .i_cycle_start(cyc), .i_temp_high(t_hi), .i_temp_low(t_lo), .i_ovp(ovp),
    .o_switch_en(sw_en), .o_boost_en(boost_en), .o_sink_en(sink_en),
    .o_led_current_code(cur), .o_ramp_up(rup), .o_ramp_down(rdn),
    .o_wire_mode(wire_m), .o_pwm_mode(pwm_m));
  bdm_link_props #(.P_EN_SD_CYC(EN_SD), .P_PWM_SD_CYC(PWM_SD),
    .P_PWM_STEP_CYC(STEP)) props_i (
    .i_mclk(i_mclk), .i_reset(i_reset), .en(bdm_link_if_i.en),
    .pwm(bdm_link_if_i.pwm), .i_ocp(ocp), .i_temp_high(t_hi), .i_ovp(ovp),
    .o_switch_en(sw_en), .o_boost_en(boost_en), .o_sink_en(sink_en),
    .o_led_current_code(cur), .o_wire_mode(wire_m), .o_pwm_mode(pwm_m));
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // One-cycle request pulse, then let the launch edge settle
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(2);
  endtask
  // Bounded wait for the host sequence to finish
  task automatic wait_idle;
    int k = 0;
    while (busy !== 1'b0) begin
      tick(1);
      k++;
      if (k > 40000) begin
        miscompares++;
        end_sim();
      end
    end
  endtask
  // Main sequence: coded mode, protections, then duty-cycle mode
  initial begin
    tick(8);
    i_reset = 1'b0;
    check({wire_m, pwm_m, bdm_link_if_i.en, bdm_link_if_i.pwm, cur}, 0);
    check({rup, rdn}, 16'h0009);
    pulse(power_wire);
    wait_idle();
    // Device sees the rise through its synchroniser a few cycles later
    tick(4);
    check({wire_m, pwm_m, wire_ready, bdm_link_if_i.en}, 16'h000B);
    frame = 16'h0805; // Code 5, fast rise, down field 2
    pulse(send);
    wait_idle();
    tick(2400);
    check(cur, 16'h0005);
    check({pwm_m, rup, rdn}, 16'h0002);
    check(sw_en, 16'h0001);
    pulse(ocp);
    check(sw_en, 16'h0000);
    pulse(cyc);
    check(sw_en, 16'h0001);
    t_lo = 1'b0;
    t_hi = 1'b1;
    tick(4);
    check({sink_en, boost_en, cur}, 16'h0000);
    t_hi = 1'b0;
    t_lo = 1'b1;
    tick(2400);
    check({sink_en, boost_en, cur}, 16'h1805);
    // Enable held low from coded mode: only the low timer ends it
    pulse(shut);
    wait_idle();
    check({wire_m, pwm_m, bdm_link_if_i.en, cur}, 16'h0000);
    check({rup, rdn}, 16'h0009);
    pulse(power_pwm);
    tick(1400);
    check({pwm_m, wire_m, pwm_run}, 16'h0005);
    tick(8000);
    check(cur < 11'h0100, 16'h0001);
    tick(9000);
    check(cur, 16'(250 * 1024 / 1000));
    pwm_high = pwm_period; // Pin held high, no edges at all
    tick(12000);
    check(cur > 11'h0100, 16'h0001);
    pwm_high = 16'h0000;
    tick(PWM_SD + 500);
    check({pwm_m, cur}, 16'h0000);
    // Fresh start in duty mode, then an over-voltage trip
    pulse(shut);
    wait_idle();
    pwm_high = 16'h00FA;
    pulse(power_pwm);
    tick(1400);
    check({pwm_m, boost_en}, 16'h0003);
    pulse(ovp);
    tick(2);
    check({pwm_m, boost_en, cur}, 16'h0000);
    check({rup, rdn}, 16'h0009);
    end_sim();
  end
endmodule
